// ### logic/sasi_regs.svh
// constants of the converter serial interface: widths, timing counts, pin slots, reset values
`ifndef SASI_REGS_SVH
`define SASI_REGS_SVH
`define SASI_RESULT_BITS 16
`define SASI_CLK_PERIOD_NS 40
`define SASI_CONV_TIME_NS 3200
`define SASI_CONV_CYCLES (`SASI_CONV_TIME_NS / `SASI_CLK_PERIOD_NS)
`define SASI_FIFO_DEPTH 16
`define SASI_PIN_CNV 0
`define SASI_PIN_SCK 1
`define SASI_PIN_SDI 2
`define SASI_PIN_COUNT 3
`define SASI_WORD_RST 16'h0000
`define SASI_SDO_RST 1'b0
`define SASI_OE_N_RST 1'b1
`endif

// ### logic/sasi_pkg.sv
// types shared by the converter serial interface
package sasi_pkg;
  typedef logic [15:0] sasi_word_t;
  typedef enum logic {SASI_MODE_CS, SASI_MODE_CHAIN} sasi_mode_e;
  typedef enum logic [1:0] {CV_IDLE, CV_CONVERT, CV_PUSH} sasi_conv_e;
  typedef enum logic [1:0] {PH_EMPTY, PH_BUSY, PH_DATA} sasi_phase_e;
endpackage

// ### logic/sasi_fifo.sv
// result fifo: memory with a registered output stage, valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sasi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // handshakes: output stage refills whenever it is empty or being taken
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count_reg != '0) && (!out_valid || out_ready);

  // storage array
  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // registered read data
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_reg[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### logic/sasi_top.sv
// conversion control and serial readout of the 16-bit converter
// Behaviour
// - a convert strobe rising edge starts sampling and conversion.
// - serial input low at that edge selects daisy-chain mode.
// - serial input high at that edge selects chip-select mode.
// - chip-select mode drives the output only while strobe or serial input is low.
// - chip-select busy indication armed if strobe or serial input low at completion.
// - chain mode passes serial input to output sixteen shift clocks later.
// - result leaves one bit per shift clock, following the host shift clock.
// - without busy indication, bit 15 appears first once the chip-select output is enabled.
// - conversion timing comes from the own clock, no shift clocks needed.
// - result is straight binary, zero at bottom, all ones at top.
`timescale 1ns/1ps
`default_nettype none
`include "sasi_regs.svh"
module sasi_top #(
  parameter int CONV_CYCLES = `SASI_CONV_CYCLES,
  parameter int FIFO_DEPTH = `SASI_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // host pins
  input wire logic convert_strobe,
  input wire logic serial_clock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  // converter core
  input wire sasi_pkg::sasi_word_t adc_code,
  // status
  output logic conversion_active,
  output logic sample_strobe
);
  import sasi_pkg::*;

  localparam int CONV_DLY = CONV_CYCLES;
  localparam int CW = $clog2(CONV_CYCLES + 1);

  logic [`SASI_PIN_COUNT-1:0] pin_meta_reg;
  logic [`SASI_PIN_COUNT-1:0] pin_sync_reg;
  logic [`SASI_PIN_COUNT-1:0] pin_prev_reg;
  logic cnv_s;
  logic sdi_s;
  logic cnv_rise;
  logic sck_fall;
  logic selected;
  sasi_mode_e mode_reg;
  sasi_conv_e conv_state_reg;
  logic [CW-1:0] conv_cnt_reg;
  sasi_word_t result_reg;
  logic busy_en_reg;
  sasi_phase_e phase_reg;
  sasi_word_t shift_reg;
  logic [4:0] bit_cnt_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  sasi_word_t fifo_out_data;
  logic conv_done;
  logic shift_now;

  // two-stage synchronisers for every host pin
  genvar gi;
  generate
    for (gi = 0; gi < `SASI_PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          pin_meta_reg[gi] <= 1'b0;
          pin_sync_reg[gi] <= 1'b0;
          pin_prev_reg[gi] <= 1'b0;
        end else begin
          pin_meta_reg[gi] <= gi == `SASI_PIN_CNV ? convert_strobe :
                              gi == `SASI_PIN_SCK ? serial_clock : serial_in;
          pin_sync_reg[gi] <= pin_meta_reg[gi];
          pin_prev_reg[gi] <= pin_sync_reg[gi];
        end
      end
    end
  endgenerate

  // edges and select level from the synchronised pins
  assign cnv_s = pin_sync_reg[`SASI_PIN_CNV];
  assign sdi_s = pin_sync_reg[`SASI_PIN_SDI];
  assign cnv_rise = cnv_s && !pin_prev_reg[`SASI_PIN_CNV];
  assign sck_fall = !pin_sync_reg[`SASI_PIN_SCK] && pin_prev_reg[`SASI_PIN_SCK];
  assign selected = !cnv_s || !sdi_s;

  // interface mode latched at the strobe edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= SASI_MODE_CS;
    end else if (cnv_rise) begin
      mode_reg <= sdi_s ? SASI_MODE_CS : SASI_MODE_CHAIN;
    end
  end

  // conversion sequencer, timed by the own clock only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_state_reg <= CV_IDLE;
      conv_cnt_reg <= '0;
    end else begin
      unique case (conv_state_reg)
        CV_IDLE: begin
          if (cnv_rise) begin
            conv_state_reg <= CV_CONVERT;
            conv_cnt_reg <= CW'(CONV_CYCLES - 1);
          end
        end
        CV_CONVERT: begin
          if (conv_cnt_reg == '0) begin
            conv_state_reg <= CV_PUSH;
          end else begin
            conv_cnt_reg <= conv_cnt_reg - 1'b1;
          end
        end
        CV_PUSH: begin
          if (fifo_in_ready) begin
            conv_state_reg <= CV_IDLE; // a full fifo holds the result here
          end
        end
      endcase
    end
  end

  // result capture: core code kept as plain straight binary
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= `SASI_WORD_RST;
    end else if (conv_state_reg == CV_CONVERT && conv_cnt_reg == '0) begin
      result_reg <= adc_code;
    end
  end

  assign conv_done = (conv_state_reg == CV_PUSH) && fifo_in_ready;

  // busy indication armed at completion; completion wins over a new strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_en_reg <= 1'b0;
    end else if (conv_done) begin
      busy_en_reg <= (mode_reg == SASI_MODE_CS) && selected;
    end else if (cnv_rise) begin
      busy_en_reg <= 1'b0;
    end
  end

  // result buffer between converter and shifter
  sasi_fifo #(
    .WIDTH(`SASI_RESULT_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(conv_state_reg == CV_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(result_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // shifter takes a word only when empty and no new strobe edge is seen
  assign fifo_pop = (phase_reg == PH_EMPTY) && !cnv_rise;
  assign shift_now = sck_fall && (mode_reg == SASI_MODE_CHAIN || selected);

  // readout phase and bit counter
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= PH_EMPTY;
      bit_cnt_reg <= '0;
    end else if (cnv_rise) begin
      phase_reg <= PH_EMPTY;
      bit_cnt_reg <= '0;
    end else begin
      unique case (phase_reg)
        PH_EMPTY: begin
          if (fifo_out_valid) begin
            phase_reg <= busy_en_reg ? PH_BUSY : PH_DATA;
            bit_cnt_reg <= '0;
          end
        end
        PH_BUSY: begin
          if (shift_now) begin
            phase_reg <= PH_DATA;
          end
        end
        PH_DATA: begin
          if (shift_now) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (mode_reg == SASI_MODE_CS && bit_cnt_reg == 5'(`SASI_RESULT_BITS - 1)) begin
              phase_reg <= PH_EMPTY;
            end
          end
        end
        default: phase_reg <= PH_EMPTY;
      endcase
    end
  end

  // shift register: loads the result, chain mode shifts serial input behind it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg <= `SASI_WORD_RST;
    end else if (phase_reg == PH_EMPTY && fifo_out_valid && !cnv_rise) begin
      shift_reg <= fifo_out_data;
    end else if (phase_reg == PH_DATA && shift_now) begin
      shift_reg <= {shift_reg[14:0], (mode_reg == SASI_MODE_CHAIN) && sdi_s};
    end
  end

  // serial output level: busy low, ready high, then msb first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      serial_out <= `SASI_SDO_RST;
    end else begin
      serial_out <= (phase_reg == PH_DATA) ? shift_reg[15] : (phase_reg == PH_BUSY);
    end
  end

  // output enable, low while driving; chain mode always drives
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      serial_out_oe_n <= `SASI_OE_N_RST;
    end else begin
      serial_out_oe_n <= (mode_reg == SASI_MODE_CS) && !selected;
    end
  end

  // status flags
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conversion_active <= 1'b0;
      sample_strobe <= 1'b0;
    end else begin
      conversion_active <= (conv_state_reg != CV_IDLE);
      sample_strobe <= cnv_rise && (conv_state_reg == CV_IDLE);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_start;
    cnv_rise && conv_state_reg == CV_IDLE |=> conv_state_reg == CV_CONVERT ##0 sample_strobe;
  endproperty
  a_start: assert property (p_start) else $error("strobe edge did not start conversion");

  property p_mode_chain;
    cnv_rise && !sdi_s |=> mode_reg == SASI_MODE_CHAIN;
  endproperty
  a_mode_chain: assert property (p_mode_chain) else $error("chain mode not selected");

  property p_mode_cs;
    cnv_rise && sdi_s |=> mode_reg == SASI_MODE_CS;
  endproperty
  a_mode_cs: assert property (p_mode_cs) else $error("chip-select mode not selected");

  property p_oe_cs;
    mode_reg == SASI_MODE_CS && !cnv_rise |=> serial_out_oe_n == $past(cnv_s && sdi_s);
  endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("output enable wrong in cs mode");

  property p_busy_arm;
    conv_done |=> busy_en_reg == ($past(mode_reg) == SASI_MODE_CS && !$past(cnv_s && sdi_s));
  endproperty
  a_busy_arm: assert property (p_busy_arm) else $error("busy indication arming wrong");

  property p_chain_pass;
    mode_reg == SASI_MODE_CHAIN && phase_reg == PH_DATA && shift_now && !cnv_rise
      |=> shift_reg[0] == $past(sdi_s) && shift_reg[15] == $past(shift_reg[14]);
  endproperty
  a_chain_pass: assert property (p_chain_pass) else $error("chain shift lost serial input");

  property p_data_bit;
    phase_reg == PH_DATA |=> serial_out == $past(shift_reg[15]);
  endproperty
  a_data_bit: assert property (p_data_bit) else $error("output bit is not shifter msb");

  property p_conv_len;
    $rose(conv_state_reg == CV_CONVERT) |-> ##[CONV_DLY:CONV_DLY] conv_state_reg == CV_PUSH;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_code;
    conv_state_reg == CV_CONVERT && conv_cnt_reg == '0 |=> result_reg == $past(adc_code);
  endproperty
  a_code: assert property (p_code) else $error("result code altered");

  property p_busy_high;
    phase_reg == PH_BUSY |=> serial_out;
  endproperty
  a_busy_high: assert property (p_busy_high) else $error("ready not shown high");

  property p_stall;
    conv_state_reg == CV_PUSH && !fifo_in_ready |=> conv_state_reg == CV_PUSH;
  endproperty
  a_stall: assert property (p_stall) else $error("result dropped on full fifo");

  c_cs_read: cover property (mode_reg == SASI_MODE_CS && phase_reg == PH_DATA && bit_cnt_reg == 5'd15);
  c_chain_read: cover property (mode_reg == SASI_MODE_CHAIN && bit_cnt_reg == 5'd16);
  c_busy: cover property (phase_reg == PH_BUSY ##[1:100] phase_reg == PH_DATA);
  c_full: cover property (conv_state_reg == CV_PUSH && !fifo_in_ready);
endmodule
`default_nettype wire

// ### tb/sasi_host_model.sv
// host controller model: convert strobe, shift clock and serial input of the converter
`timescale 1ns/1ps
`default_nettype none
module sasi_host_model (
  // clock
  input wire logic clock,
  // host pins
  output logic convert_strobe,
  output logic serial_clock,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  logic last_level;
  wire logic line_level;

  // idle pins: strobe low, shift clock parked high between frames
  initial begin
    convert_strobe = 1'b0;
    serial_clock = 1'b1;
    serial_in = 1'b1;
  end

  // a released line shows the inverse of what was last driven
  always @(posedge clock) begin
    if (serial_out_oe_n === 1'b0) last_level <= serial_out;
  end
  assign line_level = serial_out_oe_n ? ~last_level : serial_out;

  // mode level set up first, then the strobe rises with the level still held
  task automatic start(input logic cs_mode);
    @(posedge clock);
    convert_strobe <= 1'b0;
    serial_in <= cs_mode;
    repeat (3) @(posedge clock);
    convert_strobe <= 1'b1;
  endtask

  // one 320 ns shift clock per bit, sampled just before the falling edge
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      serial_in <= din[n-1-i];
      repeat (2) @(posedge clock);
      dout[n-1-i] = line_level;
      @(posedge clock);
      serial_clock <= 1'b0;
      repeat (4) @(posedge clock);
      serial_clock <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench of the converter serial interface with a host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sasi_pkg::*;
  localparam int CONV = 8;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  wire logic strobe_w, sck_w, si_w, so, so_oe_n, act, smp;
  sasi_word_t code = 16'h0000;
  sasi_word_t w;
  integer seed = 56084;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] d, din;

  // 25 MHz clock
  always #20 clock = ~clock;

  sasi_top #(.CONV_CYCLES(CONV), .FIFO_DEPTH(16)) sasi_top_i (
    .clock(clock), .reset_n(reset_n), .convert_strobe(strobe_w), .serial_clock(sck_w),
    .serial_in(si_w), .serial_out(so), .serial_out_oe_n(so_oe_n), .adc_code(code),
    .conversion_active(act), .sample_strobe(smp));

  sasi_host_model sasi_host_model_i (
    .clock(clock), .convert_strobe(strobe_w), .serial_clock(sck_w), .serial_in(si_w),
    .serial_out(so), .serial_out_oe_n(so_oe_n));

  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // chain output: own word first, then the upstream bits sixteen shifts late
  function automatic logic [31:0] chain_exp(input sasi_word_t word, input logic [31:0] up);
    return {word, up[31:16]};
  endfunction

  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // one conversion; busy 1 drops the strobe, busy 2 drops the serial input meanwhile
  task automatic conv(input logic cs_mode, input int busy);
    int k;
    sasi_host_model_i.start(cs_mode);
    k = 0;
    while (smp !== 1'b1 && k < 8) begin
      @(posedge clock);
      #1;
      k++;
    end
    check("start pulse", 32'(smp), 32'h1);
    @(posedge clock);
    #1;
    check("active at start", 32'({act, smp}), 32'h2);
    k = 0;
    while (act === 1'b1 && k < 200) begin
      @(posedge clock);
      if (k == 1 && busy == 1) sasi_host_model_i.convert_strobe <= 1'b0;
      if (k == 1 && busy == 2) sasi_host_model_i.serial_in <= 1'b0;
      #1;
      k++;
      if (k == 6 && busy != 0) check("busy wait level", 32'({so_oe_n, so}), 32'h0);
    end
    check("conversion length", 32'(k), 32'(CONV + 1));
    repeat (6) @(posedge clock);
    #1;
  endtask

  // main sequence
  initial begin
    @(posedge clock);
    #1;
    check("reset outputs", 32'({so_oe_n, so, act, smp}), 32'h8);
    @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int t = 0; t < 6; t++) begin
      w = (t == 0) ? 16'h0000 : (t == 1) ? 16'hFFFF : 16'($random(seed));
      @(posedge clock);
      code <= w;
      case (t % 3)
        0: begin
          conv(1'b1, 0);
          check("released after conversion", 32'(so_oe_n), 32'h1);
          @(posedge clock);
          sasi_host_model_i.convert_strobe <= 1'b0;
          repeat (5) @(posedge clock);
          #1;
          check("enable on strobe low", 32'(so_oe_n), 32'h0);
          check("first bit", 32'(so), 32'(w[15]));
          sasi_host_model_i.shift(16, 32'hFFFFFFFF, d);
          check("cs word", d, 32'(w));
        end
        1: begin
          conv(1'b1, (t == 1) ? 1 : 2);
          check("busy done level", 32'({so_oe_n, so}), 32'h1);
          din = (t == 1) ? 32'hFFFFFFFF : 32'h0;
          sasi_host_model_i.shift(17, din, d);
          check("busy word", d, 32'({1'b1, w}));
        end
        default: begin
          conv(1'b0, 0);
          check("chain drive", 32'(so_oe_n), 32'h0);
          din = $random(seed);
          sasi_host_model_i.shift(32, din, d);
          check("chain stream", d, chain_exp(w, din));
        end
      endcase
      $display("test %0d done", t);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
